// ### verilog/adc_trigger_host.sv
`default_nettype none

// -----------------------------------------------------------------------
// Sample FIFO with registered output stage
// -----------------------------------------------------------------------
module sample_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    logic             valid;
    logic [WIDTH-1:0] data;
  } fifo_type;

  fifo_type         cur;
  fifo_type         next_cur;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (cur.count != (PTR_W+1)'(DEPTH));
  assign out_valid = cur.valid;
  assign out_data  = cur.data;
  assign push      = in_valid && in_ready;
  assign pop       = (cur.count != '0) && (!cur.valid || out_ready);

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.wr_ptr = cur.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_cur.rd_ptr = cur.rd_ptr + 1'b1;
      next_cur.valid  = 1'b1;
      next_cur.data   = mem[cur.rd_ptr];
    end else if (out_ready) begin
      next_cur.valid = 1'b0;
    end
    case ({push, pop})
      2'b10:   next_cur.count = cur.count + 1'b1;
      2'b01:   next_cur.count = cur.count - 1'b1;
      default: next_cur.count = cur.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Storage is left out of reset; only count and the output valid flag decide what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[cur.wr_ptr] <= in_data;
    end
  end

endmodule

// -----------------------------------------------------------------------
// Converter trigger and result capture controller
// -----------------------------------------------------------------------
// Summary of operation
// - Trigger held high 20 to 50 ns
// - Trigger held low at least 20 ns
// - Trigger fall may follow strobe immediately
// - New trigger allowed right after strobe
// - Strobe rise marks result; capture it
// - Optional capture on fall: result of the same trigger
module adc_trigger_host #(
  parameter int DEPTH = adc_host_pkg::FIFO_DEPTH
) (
  input  wire logic                                   SYS_CLK,
  input  wire logic                                   RESET,
  input  wire logic                                   RUN,
  input  wire logic                                   CAPTURE_ON_FALL,
  input  wire logic                                   TWOS_COMPLEMENT,
  output logic                                        CONVERT_TRIGGER,
  input  wire logic                                   RESULT_READY_STROBE,
  input  wire logic [adc_host_pkg::RESULT_BITS_W-1:0] RESULT_BITS,
  input  wire logic                                   RESULT_MSB_INV,
  input  wire logic                                   OVER_RANGE_FLAG,
  output logic                                        SAMPLE_VALID,
  input  wire logic                                   SAMPLE_READY,
  output adc_host_pkg::sample_type                    SAMPLE_DATA,
  output logic                                        TIMEOUT_ERROR
);
  import adc_host_pkg::*;

  localparam logic [COUNT_W-1:0] HIGH_LAST =
    COUNT_W'(TRIG_HIGH_CYCLES - 1);
  localparam logic [COUNT_W-1:0] LOW_LAST =
    COUNT_W'(TRIG_LOW_CYCLES - 1);
  localparam logic [COUNT_W-1:0] WAIT_LAST =
    COUNT_W'(WAIT_LIMIT_CYCLES - 1);

  ctrl_type   cur;
  ctrl_type   next_cur;
  logic       fifo_ready;
  logic       strobe_rise;
  logic       strobe_fall;
  sample_type live_word;
  sample_type fifo_word;

  // ---------------------------------------------------------------------
  // Strobe edges and result formatting
  // ---------------------------------------------------------------------
  assign strobe_rise = RESULT_READY_STROBE && !cur.strobe_prev;
  assign strobe_fall = !RESULT_READY_STROBE && cur.strobe_prev;

  always_comb begin
    live_word.over_range = OVER_RANGE_FLAG;
    live_word.code       = RESULT_BITS;
    if (TWOS_COMPLEMENT) begin
      live_word.code[MSB_POS] = RESULT_MSB_INV;
    end
  end

  // ---------------------------------------------------------------------
  // Control sequence
  // ---------------------------------------------------------------------
  always_comb begin
    next_cur             = cur;
    next_cur.strobe_prev = RESULT_READY_STROBE;
    next_cur.push        = 1'b0;
    next_cur.timeout     = 1'b0;
    if (!cur.trig && cur.low_count != LOW_LAST) begin
      next_cur.low_count = cur.low_count + 1'b1;
    end
    case (cur.state)
      ST_IDLE: begin
        // A push still on its way is waited out before space is judged,
        // otherwise the word of one more conversion finds the FIFO full
        if (RUN && fifo_ready && !cur.push &&
            cur.low_count == LOW_LAST) begin
          next_cur.trig  = 1'b1;
          next_cur.count = HIGH_LAST;
          next_cur.state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (cur.count == '0) begin
          next_cur.trig      = 1'b0;
          next_cur.low_count = '0;
          next_cur.count     = WAIT_LAST;
          next_cur.state     = ST_WAIT_RISE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      ST_WAIT_RISE: begin
        if (strobe_rise) begin
          next_cur.count = WAIT_LAST;
          if (CAPTURE_ON_FALL) begin
            next_cur.state = ST_WAIT_FALL;
          end else begin
            // Data is already settled when the rise is seen
            next_cur.word  = live_word;
            next_cur.push  = 1'b1;
            next_cur.state = ST_IDLE;
          end
        end else if (cur.count == '0) begin
          next_cur.timeout = 1'b1;
          next_cur.state   = ST_IDLE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      ST_WAIT_FALL: begin
        if (strobe_fall) begin
          // Taken in the first cycle after the fall, inside the hold time
          next_cur.word  = live_word;
          next_cur.push  = 1'b1;
          next_cur.state = ST_IDLE;
        end else if (cur.count == '0) begin
          next_cur.timeout = 1'b1;
          next_cur.state   = ST_IDLE;
        end else begin
          next_cur.count = cur.count - 1'b1;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
        next_cur.trig  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cur           <= '0;
      cur.state     <= ST_IDLE;
      cur.low_count <= LOW_LAST;
    end else begin
      cur <= next_cur;
    end
  end

  assign CONVERT_TRIGGER = cur.trig;
  assign TIMEOUT_ERROR   = cur.timeout;
  assign SAMPLE_DATA     = fifo_word;

  // ---------------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------------
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (DEPTH)
  ) result_fifo (
    .clk       (SYS_CLK),
    .reset     (RESET),
    .in_valid  (cur.push),
    .in_ready  (fifo_ready),
    .in_data   (cur.word),
    .out_valid (SAMPLE_VALID),
    .out_ready (SAMPLE_READY),
    .out_data  (fifo_word)
  );

endmodule

`default_nettype wire

// ### verilog/adc_host_pkg.sv
`default_nettype none

package adc_host_pkg;

  // ---------------------------------------------------------------------
  // Clock and converter timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int TRIG_HIGH_MIN_NS   = 20;
  localparam int TRIG_HIGH_MAX_NS   = 50;
  localparam int TRIG_LOW_MIN_NS    = 20;
  localparam int CONVERSION_MAX_NS  = 800;
  localparam int STROBE_WIDTH_MAX_NS = 300;
  localparam int RESULT_HOLD_MIN_NS = 20;

  // Least times round up, longest times round down
  localparam int TRIG_HIGH_MIN_CYCLES =
    (TRIG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_HIGH_MAX_CYCLES = TRIG_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int TRIG_HIGH_CYCLES =
    (TRIG_HIGH_MIN_CYCLES + TRIG_HIGH_MAX_CYCLES) / 2;
  localparam int TRIG_LOW_CYCLES =
    (TRIG_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_LIMIT_CYCLES =
    (CONVERSION_MAX_NS + STROBE_WIDTH_MAX_NS) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Result word and fields
  // ---------------------------------------------------------------------
  localparam int RESULT_BITS_W = 12;
  localparam int MSB_POS       = RESULT_BITS_W - 1;
  localparam int COUNT_W       = 8;
  localparam int FIFO_DEPTH    = 16;

  typedef struct packed {
    logic                     over_range;
    logic [RESULT_BITS_W-1:0] code;
  } sample_type;

  localparam int SAMPLE_W = $bits(sample_type);

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_HIGH      = 3'b001,
    ST_WAIT_RISE = 3'b010,
    ST_WAIT_FALL = 3'b011
  } ctrl_state_type;

  typedef struct packed {
    ctrl_state_type     state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] low_count;
    logic               trig;
    logic               strobe_prev;
    logic               push;
    sample_type         word;
    logic               timeout;
  } ctrl_type;

endpackage

`default_nettype wire

// ### verif/adc_conv_model.sv
`default_nettype none

module adc_conv_model (
  input  wire logic        trig,
  input  wire logic        slow,
  input  wire logic        mute,
  input  wire logic        ovr_in,
  input  wire logic [11:0] code_in,
  output logic             strobe,
  output logic      [11:0] bits,
  output logic             msb_inv,
  output logic             ovr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    strobe = 1'b0;
    bits = 12'h000;
    msb_inv = 1'b1;
    ovr = 1'b0;
  end

  // Conversions may overlap: the next one starts while the strobe is high
  always @(posedge trig) begin
    fork
      begin
        automatic logic [12:0] held = {ovr_in, code_in};
        // Half a clock off the trigger edge, so pins never move on a rising edge
        #(slow ? 605 : 205);
        if (!mute) begin
          {ovr, bits} = held;
          msb_inv = ~held[11];
          #30 strobe = 1'b1;
          #150 strobe = 1'b0;
        end
      end
    join_none
  end
endmodule

`default_nettype wire

// ### verif/adc_host_assertions.sv
`default_nettype none

module adc_host_assertions (
  input wire logic                    SYS_CLK,
  input wire logic                    RESET,
  input wire logic                    RUN,
  input wire logic                    CAPTURE_ON_FALL,
  input wire logic                    CONVERT_TRIGGER,
  input wire logic                    RESULT_READY_STROBE,
  input wire logic                    SAMPLE_VALID,
  input wire logic                    SAMPLE_READY,
  input wire adc_host_pkg::sample_type SAMPLE_DATA,
  input wire logic                    TIMEOUT_ERROR
);
  import adc_host_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  logic busy;
  logic done;
  logic risen;
  assign done = TIMEOUT_ERROR;

  // Strobe rose since the latest trigger; only then does a fall close it
  always_ff @(posedge SYS_CLK) begin
    if (RESET)
      risen <= 1'b0;
    else if ($rose(CONVERT_TRIGGER))
      risen <= 1'b0;
    else if ($rose(RESULT_READY_STROBE))
      risen <= 1'b1;
  end

  // Conversion outstanding from trigger until its completion edge or a timeout
  always_ff @(posedge SYS_CLK) begin
    if (RESET)
      busy <= 1'b0;
    else if ($rose(CONVERT_TRIGGER))
      busy <= 1'b1;
    else if (done ||
             (CAPTURE_ON_FALL ? $fell(RESULT_READY_STROBE) && risen
                              : $rose(RESULT_READY_STROBE)))
      busy <= 1'b0;
  end

  sequence trig_pulse;
    CONVERT_TRIGGER[*3] ##1 !CONVERT_TRIGGER;
  endsequence
  sequence restart;
    ##[1:3] $rose(CONVERT_TRIGGER);
  endsequence

  trig_high_width_a: assert property (
    $rose(CONVERT_TRIGGER) |-> trig_pulse)
    else $error("trigger width wrong");
  trig_low_width_a: assert property (
    $fell(CONVERT_TRIGGER) |-> !CONVERT_TRIGGER[*2])
    else $error("trigger low too short");
  one_per_result_a: assert property (
    $rose(CONVERT_TRIGGER) |-> !busy)
    else $error("trigger before completion");
  trig_done_first_a: assert property (
    $rose(RESULT_READY_STROBE) |-> !CONVERT_TRIGGER)
    else $error("trigger high at strobe");
  restart_rise_a: assert property (
    $rose(RESULT_READY_STROBE) && !CAPTURE_ON_FALL && RUN &&
    SAMPLE_READY |-> restart)
    else $error("no restart after rise");
  restart_fall_a: assert property (
    $fell(RESULT_READY_STROBE) && risen && CAPTURE_ON_FALL && RUN &&
    SAMPLE_READY |-> restart)
    else $error("no restart after fall");
  word_hold_a: assert property (
    SAMPLE_VALID && !SAMPLE_READY |=> SAMPLE_VALID && $stable(SAMPLE_DATA))
    else $error("word not held");
endmodule

bind adc_trigger_host adc_host_assertions i_chk (.SYS_CLK, .RESET, .RUN,
  .CAPTURE_ON_FALL, .CONVERT_TRIGGER, .RESULT_READY_STROBE, .SAMPLE_VALID,
  .SAMPLE_READY, .SAMPLE_DATA, .TIMEOUT_ERROR);

`default_nettype wire

// ### verif/adc_trigger_host_tb.sv
`default_nettype none

module adc_trigger_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_host_pkg::*;
  localparam int FILL = FIFO_DEPTH + 1;
  logic       sys_clk, reset, run, cof, twos, sample_ready, ready_idle;
  logic       trig, strobe, msb_inv, ovr, valid, slow, ovr_in, tmo, mute;
  logic [11:0] bits, code_in;
  sample_type data;
  int         mismatches, compares, rises;

  adc_trigger_host i_dut (.SYS_CLK(sys_clk), .RESET(reset), .RUN(run),
    .CAPTURE_ON_FALL(cof), .TWOS_COMPLEMENT(twos), .CONVERT_TRIGGER(trig),
    .RESULT_READY_STROBE(strobe), .RESULT_BITS(bits),
    .RESULT_MSB_INV(msb_inv), .OVER_RANGE_FLAG(ovr), .SAMPLE_VALID(valid),
    .SAMPLE_READY(sample_ready), .SAMPLE_DATA(data), .TIMEOUT_ERROR(tmo));
  adc_conv_model i_conv (.trig(trig), .slow(slow), .mute(mute),
    .ovr_in(ovr_in),
    .code_in(code_in), .strobe(strobe), .bits(bits), .msb_inv(msb_inv),
    .ovr(ovr));

  always @(posedge trig) rises++;

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input sample_type got, input sample_type exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic sample_type expw(input logic o, input logic [11:0] c);
    return {o, twos ? ~c[11] : c[11], c[10:0]};
  endfunction

  task automatic pop(output sample_type w);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    w = data;
    sample_ready = 1'b1;
    @(negedge sys_clk);
    sample_ready = ready_idle;
  endtask

  task automatic single(input logic f, t, o, s, input logic [11:0] c);
    sample_type w;
    cof = f;
    twos = t;
    ovr_in = o;
    slow = s;
    code_in = c;
    run = 1'b1;
    @(posedge trig);
    @(negedge sys_clk);
    run = 1'b0;
    code_in = ~c;
    pop(w);
    chk(w, expw(o, c));
    $display("single %h done", c);
  endtask

  task automatic stream(input logic f);
    sample_type w;
    sample_type q[$];
    cof = f;
    ready_idle = 1'b1;
    sample_ready = 1'b1;
    code_in = 12'h123;
    run = 1'b1;
    fork
      for (int i = 0; i < 4; i++) begin
        @(posedge trig);
        q.push_back(expw(ovr_in, code_in));
        @(negedge sys_clk);
        code_in = code_in + 12'h351;
        if (i == 3)
          run = 1'b0;
      end
      for (int j = 0; j < 4; j++) begin
        pop(w);
        chk(w, q.pop_front());
      end
    join
    ready_idle = 1'b0;
    sample_ready = 1'b0;
    $display("stream %0d done", f);
  endtask

  task automatic fill;
    sample_type w;
    int n;
    cof = 1'b0;
    code_in = 12'h5a5;
    ovr_in = 1'b1;
    slow = 1'b1;
    n = rises;
    run = 1'b1;
    repeat (1400) @(negedge sys_clk);
    chk_n(rises - n, FILL);
    run = 1'b0;
    repeat (FILL) begin
      pop(w);
      chk(w, expw(1'b1, 12'h5a5));
    end
    n = 0;
    repeat (50) begin
      @(negedge sys_clk);
      if (valid === 1'b1)
        n++;
    end
    chk_n(n, 0);
    $display("fill done");
  endtask

  task automatic lost;
    int n;
    mute = 1'b1;
    run = 1'b1;
    @(posedge trig);
    @(negedge sys_clk);
    run = 1'b0;
    n = 0;
    while (tmo !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk_n(n, TRIG_HIGH_CYCLES + WAIT_LIMIT_CYCLES);
    @(negedge sys_clk);
    chk_n(int'(tmo === 1'b0 && valid === 1'b0), 1);
    mute = 1'b0;
    $display("lost done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test;
  end

  initial begin
    {reset, run, cof, twos, sample_ready, ready_idle} = 6'h21;
    {mute, slow, ovr_in, code_in, mismatches, compares, rises} = '0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    single(1'b0, 1'b0, 1'b0, 1'b0, 12'h800);
    single(1'b0, 1'b1, 1'b1, 1'b1, 12'h7ff);
    single(1'b1, 1'b0, 1'b1, 1'b0, 12'h001);
    single(1'b1, 1'b1, 1'b0, 1'b1, 12'hffe);
    stream(1'b0);
    stream(1'b1);
    fill;
    lost;
    stop_test;
  end
endmodule

`default_nettype wire
